// >>> core/psm_top.sv
// Phase shedding manager: phase count, shedding thresholds, droop gain, current averaging
`timescale 1ns/10ps
module psm_top
  import psm_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // Register port
  input wire logic [3:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  // Comparator, strap and event pins
  input wire logic CMP_ABOVE_RISE,
  input wire logic CMP_BELOW_FALL,
  input wire logic THIRD_PHASE_DRIVE_GND,
  input wire logic FOURTH_PHASE_DRIVE_GND,
  input wire logic OUTPUT_OK_FLAG,
  input wire logic VOLTAGE_TARGET_TRANSITION,
  input wire logic LOAD_STEP,
  // Per-phase current information
  input wire logic [3:0][7:0] PHASE_CURRENT,
  // Phase control and analog settings
  output logic [3:0] PHASE_ENABLE,
  output logic [1:0] SHED_THRESHOLD_CODE,
  output logic [11:0] SHED_RISE_LEVEL_MV,
  output logic [11:0] SHED_FALL_LEVEL_MV,
  output logic [1:0] CORE_DROOP_GAIN,
  output psm_trim_t PHASE_TRIM
);

  // ---------------------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------------------
  function automatic logic [11:0] pct_mv(input logic [5:0] pct);
    logic [16:0] prod;
    prod = {11'h000, pct} * FULL_LOAD_MV;
    return 12'(prod / FULL_PCT);
  endfunction

  function automatic logic [3:0] phase_mask(input logic [2:0] n);
    logic [4:0] one_hot;
    one_hot = 5'h01 << n;
    return 4'(one_hot - 5'h01);
  endfunction

  function automatic logic [9:0] div_by_n(input logic [9:0] sum, input logic [2:0] n);
    // Three working phases: the quotient truncates
    case (n)
      PH_ONE: return sum;
      PH_TWO: return sum >> 1;
      PH_THREE: return sum / 10'h003;
      PH_FOUR: return sum >> 2;
      default: return sum;
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------------------
  logic [SYNC_W-1:0] pins;
  logic [SYNC_W-1:0] pins_s;
  logic above_s;
  logic below_s;
  logic ok_s;
  logic event_s;

  assign pins[S_ABOVE] = CMP_ABOVE_RISE;
  assign pins[S_BELOW] = CMP_BELOW_FALL;
  assign pins[S_PH3GND] = THIRD_PHASE_DRIVE_GND;
  assign pins[S_PH4GND] = FOURTH_PHASE_DRIVE_GND;
  assign pins[S_OK] = OUTPUT_OK_FLAG;
  assign pins[S_VTT] = VOLTAGE_TARGET_TRANSITION;
  assign pins[S_STEP] = LOAD_STEP;

  // Only the second flop of each pin is read
  psm_sync u_sync (
    .CORE_CLK(CORE_CLK),
    .RESET_N(RESET_N),
    .D(pins),
    .Q(pins_s)
  );

  assign above_s = pins_s[S_ABOVE];
  assign below_s = pins_s[S_BELOW];
  assign ok_s = pins_s[S_OK];
  // Either event resets shedding; both are level inputs
  assign event_s = pins_s[S_VTT] | pins_s[S_STEP];

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  psm_st_t st;
  psm_st_t next_st;
  logic [2:0] work_n;
  logic [9:0] cur_sum;
  logic [2:0] en_n;

  always_comb begin
    next_st = st;
    next_st.rdata = 16'h0000;
    // Strap capture once the synchronised strap levels have settled
    if (!st.straps_done) begin
      next_st.strap_cnt = st.strap_cnt + 2'h1;
      if (st.strap_cnt == STRAP_WAIT) begin
        next_st.straps_done = 1'b1;
        // Third drive grounded means two phases whatever the fourth does
        if (pins_s[S_PH3GND]) begin
          next_st.strap_n = PH_TWO;
        end else if (pins_s[S_PH4GND]) begin
          next_st.strap_n = PH_THREE;
        end else begin
          next_st.strap_n = PH_FOUR;
        end
      end
    end
    // Register writes
    if (REG_WR) begin
      case (REG_ADDR)
        ADDR_FLAGS: begin
          // Enable is dropped while the output is not yet reported ok
          next_st.shed_en = REG_WDATA[FLAG_SHED_EN] & ok_s;
          next_st.strategy = REG_WDATA[FLAG_STRATEGY];
          next_st.th_code = REG_WDATA[FLAG_TH_HI:FLAG_TH_LO];
        end
        ADDR_DROOP: begin
          if (REG_WDATA[DROOP_HI:DROOP_LO] != DROOP_IGNORED) begin
            next_st.droop = REG_WDATA[DROOP_HI:DROOP_LO];
          end
        end
        default: begin
        end
      endcase
    end
    // Register reads, data valid in the following cycle only
    if (REG_RD) begin
      case (REG_ADDR)
        ADDR_FLAGS: next_st.rdata = {11'h000, st.th_code, st.strategy, 1'b0, st.shed_en};
        ADDR_DROOP: next_st.rdata = {14'h0000, st.droop};
        ADDR_STATUS: next_st.rdata = {7'h00, ok_s, st.state == ST_HOLD, st.shed, st.strap_n, work_n};
        ADDR_AVG: next_st.rdata = {6'h00, st.trim.avg};
        default: next_st.rdata = 16'h0000;
      endcase
    end
    // Shedding sequencer
    case (st.state)
      ST_IDLE: begin
        next_st.shed = 1'b0;
        // An event in the enable cycle still starts the re-arm delay
        if (st.shed_en && event_s) begin
          next_st.state = ST_HOLD;
          next_st.hold_cnt = REARM_LOAD;
        end else if (st.shed_en) begin
          next_st.state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (event_s) begin
          next_st.state = ST_HOLD;
          next_st.shed = 1'b0;
          next_st.hold_cnt = REARM_LOAD;
        end else if (!st.shed && below_s) begin
          next_st.shed = 1'b1;
        end else if (st.shed && above_s) begin
          next_st.shed = 1'b0;
        end
      end
      ST_HOLD: begin
        // Any event restarts the full delay, so re-arm follows the last quiet cycle
        next_st.shed = 1'b0;
        if (event_s) begin
          next_st.hold_cnt = REARM_LOAD;
        end else if (st.hold_cnt == 12'h001) begin
          next_st.state = ST_ACTIVE;
          next_st.shed = below_s;
        end else begin
          next_st.hold_cnt = st.hold_cnt - 12'h001;
        end
      end
      default: begin
        next_st.state = ST_IDLE;
      end
    endcase
    // Clearing enable wins over every sequencer step
    if (!next_st.shed_en) begin
      next_st.state = ST_IDLE;
      next_st.shed = 1'b0;
    end
    // Threshold levels as fractions of full load
    next_st.rise_mv = pct_mv(6'(RISE_BASE_PCT + STEP_PCT * {4'h0, st.th_code}));
    next_st.fall_mv = pct_mv(6'(FALL_BASE_PCT + STEP_PCT * {4'h0, st.th_code}));
    // No phase runs until the straps are known
    next_st.phase_en = st.straps_done ? phase_mask(work_n) : 4'h0;
    // Current averaging and per-phase error
    // Divide by the phases that carried current, not by the target count
    next_st.trim.avg = div_by_n(cur_sum, en_n);
    for (int i = 0; i < 4; i++) begin
      next_st.trim.err[i] = st.phase_en[i] ? 11'({3'h0, PHASE_CURRENT[i]} - {1'b0, st.trim.avg}) : 11'h000;
    end
  end

  always_comb begin
    work_n = st.shed ? (st.strategy ? PH_TWO : PH_ONE) : st.strap_n;
    cur_sum = 10'h000;
    en_n = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (st.phase_en[i]) begin
        cur_sum = cur_sum + {2'h0, PHASE_CURRENT[i]};
        en_n = en_n + 3'h1;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st <= '0;
      st.state <= ST_IDLE;
      st.strap_n <= PH_FOUR;
      st.droop <= DROOP_QUARTER;
      st.th_code <= TH_DEFAULT;
      st.hold_cnt <= REARM_LOAD;
      st.rise_mv <= RISE_MV_RESET;
      st.fall_mv <= FALL_MV_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign REG_RDATA = st.rdata;
  assign PHASE_ENABLE = st.phase_en;
  assign SHED_THRESHOLD_CODE = st.th_code;
  assign SHED_RISE_LEVEL_MV = st.rise_mv;
  assign SHED_FALL_LEVEL_MV = st.fall_mv;
  assign CORE_DROOP_GAIN = st.droop;
  assign PHASE_TRIM = st.trim;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  // All checks run on the core clock and are off during reset
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  a_shed_entry_fall: assert property ((st.state == ST_ACTIVE) && !st.shed && below_s && !event_s && st.shed_en
    && !REG_WR |=> st.shed) else $error("shedding not entered below falling threshold");
  a_restore_rise: assert property ((st.state == ST_ACTIVE) && st.shed && above_s && !below_s && !event_s
    && !REG_WR |=> !st.shed) else $error("phases not restored above rising threshold");
  a_thresh_levels: assert property ($past(st.th_code) == 2'h3 |-> st.rise_mv == 12'h276
    && st.fall_mv == 12'h21c) else $error("threshold levels wrong for code 11");
  a_thresh_scale: assert property ($past(st.th_code) == 2'h0 |-> st.rise_mv == 12'h168
    && st.fall_mv == 12'h10e) else $error("threshold levels wrong for code 00");
  a_disabled_full: assert property (!st.shed_en |=> !st.shed ##1 !st.shed || st.shed_en)
    else $error("shedding active while disabled");
  a_enable_gate: assert property (REG_WR && REG_ADDR == ADDR_FLAGS && !ok_s |=> !st.shed_en)
    else $error("enable accepted before output ok");
  a_compare_gate: assert property (st.state == ST_IDLE |-> !st.shed)
    else $error("comparison acting before enable");
  a_event_reset: assert property (event_s && st.shed_en && !REG_WR |=> !st.shed && st.state == ST_HOLD)
    else $error("event did not reset shedding");
  a_rearm_delay: assert property (st.state == ST_HOLD && st.hold_cnt == 12'h001 && !event_s
    && !REG_WR |=> st.state == ST_ACTIVE && st.shed == $past(below_s)) else $error("re-arm after delay failed");
  a_shed_count: assert property (st.shed && st.straps_done |=>
    PHASE_ENABLE == ($past(st.strategy) ? 4'h3 : 4'h1) || !st.shed) else $error("shed phase count wrong");
  a_droop_ignore: assert property (REG_WR && REG_ADDR == ADDR_DROOP && REG_WDATA[1:0] == 2'h2 |=>
    $stable(CORE_DROOP_GAIN)) else $error("ignored droop code changed gain");
  a_avg_two: assert property (st.phase_en == 4'h3 |=> PHASE_TRIM.avg ==
    10'(({2'h0, $past(PHASE_CURRENT[0])} + {2'h0, $past(PHASE_CURRENT[1])}) >> 1)) else $error("average wrong");
  a_strap_three: assert property (st.straps_done && !st.shed && st.strap_n == PH_THREE
    |=> PHASE_ENABLE == 4'h7) else $error("three-phase strap not applied");
  a_full_restore: assert property (st.straps_done && !st.shed && st.strap_n == PH_FOUR
    |=> PHASE_ENABLE == 4'hf) else $error("strapped phase count not restored");
  a_idle_err: assert property (!st.phase_en[3] |=> PHASE_TRIM.err[3] == 11'h000)
    else $error("idle phase carries a trim error");

  c_shed_enter: cover property (!st.shed ##1 st.shed);
  c_event_hold: cover property (st.state == ST_ACTIVE ##1 st.state == ST_HOLD);
  c_rearm: cover property (st.state == ST_HOLD ##1 st.state == ST_ACTIVE);
  c_restore: cover property (st.shed ##1 !st.shed && st.state == ST_ACTIVE);
  c_shed_two: cover property (st.shed && st.strategy);

endmodule // psm_top

// >>> core/psm_pkg.sv
// Package: constants, types and register map for the phase shedding manager
package psm_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int REARM_DELAY_NS = 10000;
  localparam int REARM_CYC = (REARM_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [11:0] REARM_LOAD = 12'(REARM_CYC);
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  // ---------------------------------------------------------------------------
  // Register map (word index on REG_ADDR) and field positions
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ADDR_FLAGS = 4'h0;
  localparam logic [3:0] ADDR_DROOP = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_AVG = 4'h3;
  localparam int FLAG_SHED_EN = 0;
  localparam int FLAG_STRATEGY = 2;
  localparam int FLAG_TH_LO = 3;
  localparam int FLAG_TH_HI = 4;
  localparam int DROOP_LO = 0;
  localparam int DROOP_HI = 1;
  localparam logic [1:0] DROOP_QUARTER = 2'h0;
  localparam logic [1:0] DROOP_IGNORED = 2'h2;
  localparam logic [1:0] TH_DEFAULT = 2'h0;

  // ---------------------------------------------------------------------------
  // Threshold scaling
  // ---------------------------------------------------------------------------
  localparam logic [16:0] FULL_LOAD_MV = 17'h00708;
  localparam logic [16:0] FULL_PCT = 17'h00064;
  localparam logic [5:0] RISE_BASE_PCT = 6'h14;
  localparam logic [5:0] FALL_BASE_PCT = 6'h0f;
  localparam logic [5:0] STEP_PCT = 6'h05;
  localparam logic [11:0] RISE_MV_RESET = 12'h168;
  localparam logic [11:0] FALL_MV_RESET = 12'h10e;

  // ---------------------------------------------------------------------------
  // Phase counts and synchroniser layout
  // ---------------------------------------------------------------------------
  localparam logic [2:0] PH_TWO = 3'h2;
  localparam logic [2:0] PH_THREE = 3'h3;
  localparam logic [2:0] PH_FOUR = 3'h4;
  localparam logic [2:0] PH_ONE = 3'h1;
  localparam int SYNC_W = 7;
  localparam int S_ABOVE = 0;
  localparam int S_BELOW = 1;
  localparam int S_PH3GND = 2;
  localparam int S_PH4GND = 3;
  localparam int S_OK = 4;
  localparam int S_VTT = 5;
  localparam int S_STEP = 6;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_ACTIVE, ST_HOLD} psm_state_t;

  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] sync;
  } psm_sync_st_t;

  typedef struct packed {
    logic [9:0] avg;
    logic [3:0][10:0] err;
  } psm_trim_t;

  typedef struct packed {
    psm_state_t state;
    logic [1:0] strap_cnt;
    logic straps_done;
    logic [2:0] strap_n;
    logic shed_en;
    logic strategy;
    logic [1:0] th_code;
    logic [1:0] droop;
    logic shed;
    logic [11:0] hold_cnt;
    logic [15:0] rdata;
    logic [3:0] phase_en;
    logic [11:0] rise_mv;
    logic [11:0] fall_mv;
    psm_trim_t trim;
  } psm_st_t;

endpackage

// >>> core/psm_sync.sv
// Two-flop synchroniser for the asynchronous pin inputs
`timescale 1ns/10ps
module psm_sync
  import psm_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // Pins in, synchronised levels out
  input wire logic [SYNC_W-1:0] D,
  output logic [SYNC_W-1:0] Q
);

  psm_sync_st_t st;
  psm_sync_st_t next_st;

  always_comb begin
    next_st.meta = D;
    next_st.sync = st.meta;
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign Q = st.sync;

endmodule // psm_sync

// >>> testbench/psm_analog_model.sv
// Analog side model: threshold comparators and phase current sources
`timescale 1ns/10ps
module psm_analog_model
  import psm_pkg::*;
(
  // Sensed level and load per phase
  input wire logic [11:0] sense_mv,
  input wire logic [3:0][7:0] load,
  // Levels and enables from the block
  input wire logic [11:0] rise_mv,
  input wire logic [11:0] fall_mv,
  input wire logic [3:0] phase_en,
  // Back to the block
  output logic above,
  output logic below,
  output logic [3:0][7:0] phase_cur
);
  assign above = sense_mv > rise_mv;
  assign below = sense_mv < fall_mv;
  // An idle phase carries no current
  always_comb
    for (int i = 0; i < 4; i++)
      phase_cur[i] = phase_en[i] ? load[i] : 8'h00;
endmodule // psm_analog_model

// >>> testbench/dynamic_phase_manager_bench.sv
// Self-checking bench for the phase shedding manager
`timescale 1ns/10ps
module dynamic_phase_manager_bench
  import psm_pkg::*;
;
  typedef struct {int kind; logic [15:0] val;} psm_note_t;
  logic clk = 0;
  logic rst_n = 0;
  logic [3:0] addr = '0;
  logic [15:0] wdata = '0;
  logic wr = 0;
  logic rd = 0;
  logic gnd3 = 0;
  logic gnd4 = 0;
  logic ok_flag = 0;
  logic vtt = 0;
  logic step = 0;
  logic [11:0] sense = 12'h7ff;
  logic [3:0][7:0] load = '0;
  logic [15:0] rdata;
  logic above, below;
  logic [3:0][7:0] cur;
  logic [3:0] pe;
  logic [1:0] code, droop;
  logic [11:0] rise, fall;
  psm_trim_t trim;
  psm_note_t notes[$];
  int bad_count = 0;
  int compares = 0;
  logic rd_q = 0;
  logic probe = 0;
  logic [31:0] rng = 32'h9df7;
  string names[9] = '{"rdata", "phase_en", "code", "rise", "fall", "droop", "avg", "err0", "err3"};
  logic [3:0] strap_pe[4] = '{4'hf, 4'h7, 4'h3, 4'h3};

  psm_top i_psm_top (.CORE_CLK(clk), .RESET_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .CMP_ABOVE_RISE(above), .CMP_BELOW_FALL(below),
    .THIRD_PHASE_DRIVE_GND(gnd3), .FOURTH_PHASE_DRIVE_GND(gnd4), .OUTPUT_OK_FLAG(ok_flag),
    .VOLTAGE_TARGET_TRANSITION(vtt), .LOAD_STEP(step), .PHASE_CURRENT(cur), .PHASE_ENABLE(pe),
    .SHED_THRESHOLD_CODE(code), .SHED_RISE_LEVEL_MV(rise), .SHED_FALL_LEVEL_MV(fall),
    .CORE_DROOP_GAIN(droop), .PHASE_TRIM(trim));
  psm_analog_model i_psm_analog_model (.sense_mv(sense), .load(load), .rise_mv(rise), .fall_mv(fall),
    .phase_en(pe), .above(above), .below(below), .phase_cur(cur));

  // ---------------------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------------------
  task automatic conclude();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(string nm, logic [15:0] s, logic [15:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, s);
    end
  endtask

  function automatic logic [15:0] seen(int k);
    case (k)
      0: return rdata;
      1: return 16'(pe);
      2: return 16'(code);
      3: return 16'(rise);
      4: return 16'(fall);
      5: return 16'(droop);
      6: return 16'(trim.avg);
      7: return 16'(trim.err[0]);
      default: return 16'(trim.err[3]);
    endcase
  endfunction

  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // Takes the oldest note whenever read data or a probed output is due
  always @(posedge clk) begin
    psm_note_t n;
    rd_q <= rd;
    if (rd_q || probe) begin
      if (notes.size() == 0) begin
        bad_count++;
        $display("unexpected result with no note");
      end else begin
        n = notes.pop_front();
        check(names[n.kind], seen(n.kind), n.val);
      end
    end
  end

  task automatic expect_pin(int k, logic [15:0] v);
    @(posedge clk);
    notes.push_back('{k, v});
    probe <= 1;
    @(posedge clk);
    probe <= 0;
  endtask

  task automatic write_reg(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask

  task automatic read_reg(logic [3:0] a, logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    notes.push_back('{0, e});
    @(posedge clk);
    rd <= 0;
  endtask

  task automatic wait_pe(logic [3:0] v, int lim);
    int i;
    for (i = 0; i < lim && pe !== v; i++)
      @(posedge clk);
    if (i == lim) begin
      bad_count++;
      $display("unexpected wait: phase_en %h never came", v);
      conclude();
    end
  endtask

  task automatic do_reset(logic g3, logic g4);
    rst_n <= 0;
    gnd3 <= g3;
    gnd4 <= g4;
    repeat (10) @(posedge clk);
    rst_n <= 1;
    repeat (8) @(posedge clk);
  endtask

  // ---------------------------------------------------------------------------
  // Clock and main sequence
  // ---------------------------------------------------------------------------
  initial begin
    forever #2.5 clk = ~clk;
  end

  initial begin
    logic [7:0] l0, l1;
    logic [9:0] av;
    logic [10:0] e0;
    expect_pin(1, 16'h0000);
    expect_pin(2, 16'h0000);
    expect_pin(3, 16'h0168);
    expect_pin(4, 16'h010e);
    expect_pin(5, 16'h0000);
    for (int s = 3; s >= 0; s--) begin
      do_reset(s[1], s[0]);
      expect_pin(1, 16'(strap_pe[s]));
    end
    read_reg(ADDR_FLAGS, 16'h0000);
    read_reg(4'hf, 16'h0000);
    write_reg(ADDR_DROOP, 16'h0001);
    expect_pin(5, 16'h0001);
    write_reg(ADDR_DROOP, 16'h0002);
    expect_pin(5, 16'h0001);
    write_reg(ADDR_DROOP, 16'h0003);
    expect_pin(5, 16'h0003);
    for (int c = 0; c < 4; c++) begin
      write_reg(ADDR_FLAGS, 16'((c << 3) | 1));
      expect_pin(2, 16'(c));
      expect_pin(3, 16'(18 * (20 + 5 * c)));
      expect_pin(4, 16'(18 * (15 + 5 * c)));
      read_reg(ADDR_FLAGS, 16'(c << 3));
    end
    // Low load before enabling must not shed
    write_reg(ADDR_FLAGS, 16'h0000);
    sense <= 12'h064;
    ok_flag <= 1;
    repeat (10) @(posedge clk);
    expect_pin(1, 16'h000f);
    write_reg(ADDR_FLAGS, 16'h0001);
    wait_pe(4'h1, 8);
    read_reg(ADDR_STATUS, 16'h0161);
    sense <= 12'h12c;
    repeat (10) @(posedge clk);
    expect_pin(1, 16'h0001);
    sense <= 12'h190;
    wait_pe(4'hf, 6);
    write_reg(ADDR_FLAGS, 16'h0005);
    sense <= 12'h064;
    wait_pe(4'h3, 10);
    rng = xs(rng);
    l0 = rng[7:0];
    l1 = rng[15:8];
    load <= {rng[31:16], l1, l0};
    av = ({2'h0, l0} + {2'h0, l1}) >> 1;
    e0 = {3'h0, l0} - {1'h0, av};
    repeat (4) @(posedge clk);
    expect_pin(6, 16'(av));
    expect_pin(7, 16'(e0));
    expect_pin(8, 16'h0000);
    read_reg(ADDR_AVG, 16'(av));
    for (int e = 0; e < 2; e++) begin
      if (e == 0)
        vtt <= 1;
      else
        step <= 1;
      wait_pe(4'hf, 6);
      read_reg(ADDR_STATUS, 16'h01a4);
      vtt <= 0;
      step <= 0;
      repeat (REARM_CYC - 20) @(posedge clk);
      expect_pin(1, 16'h000f);
      wait_pe(4'h3, 40);
    end
    write_reg(ADDR_FLAGS, 16'h0000);
    wait_pe(4'hf, 6);
    conclude();
  end
endmodule // dynamic_phase_manager_bench
